//--- src/alt_reader_regs.vh
/*
 * Constants for the altimeter serial reader: type codes, framing,
 * baud rates, ASCII codes and poll timing.
 * Assumes inclusion by bare name from the design files under src/.
 */
`ifndef ALT_READER_REGS_VH
`define ALT_READER_REGS_VH

// ********
// Altimeter type codes
// ********
`define ALT_TYPE_MARK7     2'h0
`define ALT_TYPE_BATHY     2'h1
`define ALT_TYPE_DUAL      2'h2
`define ALT_TYPE_POLLED    2'h3

// ********
// Baud rates and clock
// ********
`define CLK_HZ             40000000
`define BAUD_MARK7         2400
`define BAUD_BATHY         9600
`define BAUD_DUAL          4800
`define BAUD_POLLED        9600

// ********
// Framing per type
// ********
`define BITS_SEVEN         4'h7
`define BITS_EIGHT         4'h8
`define STOP_ONE           2'h1
`define STOP_TWO           2'h2

// ********
// ASCII codes
// ********
`define CH_CR              8'h0D
`define CH_LF              8'h0A
`define CH_SPACE           8'h20
`define CH_COMMA           8'h2C
`define CH_DOT             8'h2E
`define CH_MINUS           8'h2D
`define CH_ZERO            8'h30
`define CH_NINE            8'h39
`define CH_D               8'h44
`define CH_T               8'h54
`define CH_R               8'h52

// ********
// Poll timing and line limits
// ********
`define POLL_PERIOD_MS     200
`define MAX_LINE_CHARS     8'h40

`endif

//--- src/uart_frame_rx.v
/*
 * Asynchronous serial character receiver with run-time data width,
 * stop bit count and optional mark (eighth, always high) bit.
 * Assumes rx_line is already synchronous to core_clk.
 */
`default_nettype none
`include "alt_reader_regs.vh"

module uart_frame_rx #(
    parameter DIV_W = 16
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             sys_rst,
    // Framing setup
    input  wire [DIV_W-1:0] bit_div,
    input  wire [3:0]       data_bits,
    input  wire             mark_bit,
    input  wire [1:0]       stop_bits,
    // Line and result
    input  wire             rx_line,
    output reg  [7:0]       rx_data_q,
    output reg              rx_valid_q,
    output reg              rx_err_q
);

    localparam S_IDLE = 4'b0001;
    localparam S_START = 4'b0010;
    localparam S_DATA = 4'b0100;
    localparam S_STOP = 4'b1000;

    reg [3:0]       state_q;
    reg [DIV_W-1:0] cnt_q;
    reg [3:0]       bit_q;
    reg [7:0]       shift_q;

    // ********
    // Receive state machine, sampling mid-bit
    // ********
    always @(posedge core_clk) begin
        if (sys_rst) begin
            state_q    <= S_IDLE;
            cnt_q      <= {DIV_W{1'b0}};
            bit_q      <= 4'h0;
            shift_q    <= 8'h00;
            rx_data_q  <= 8'h00;
            rx_valid_q <= 1'b0;
            rx_err_q   <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            rx_err_q   <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (!rx_line) begin
                        state_q <= S_START;
                        cnt_q   <= {1'b0, bit_div[DIV_W-1:1]};
                    end
                end
                S_START: begin
                    if (cnt_q != {DIV_W{1'b0}}) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else if (rx_line) begin
                        state_q <= S_IDLE; // Glitch, not a start bit
                    end else begin
                        state_q <= S_DATA;
                        cnt_q   <= bit_div;
                        bit_q   <= 4'h0;
                        shift_q <= 8'h00;
                    end
                end
                S_DATA: begin
                    if (cnt_q != {DIV_W{1'b0}}) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        cnt_q   <= bit_div;
                        shift_q <= {rx_line, shift_q[7:1]};
                        bit_q   <= bit_q + 4'h1;
                        // Mark bit is read as an extra data bit and dropped
                        if (bit_q + 4'h1 == data_bits + {3'b000, mark_bit}) begin
                            state_q <= S_STOP;
                            bit_q   <= 4'h0;
                        end
                    end
                end
                S_STOP: begin
                    if (cnt_q != {DIV_W{1'b0}}) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else if (!rx_line) begin
                        state_q  <= S_IDLE;
                        rx_err_q <= 1'b1;
                    end else if (bit_q + 4'h1 < {2'b00, stop_bits}) begin
                        bit_q <= bit_q + 4'h1;
                        cnt_q <= bit_div;
                    end else begin
                        state_q    <= S_IDLE;
                        rx_valid_q <= 1'b1;
                        // Right-align by received width
                        if (mark_bit)
                            rx_data_q <= {1'b0, shift_q[6:0]};
                        else if (data_bits == `BITS_SEVEN)
                            rx_data_q <= {1'b0, shift_q[7:1]};
                        else
                            rx_data_q <= shift_q;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

endmodule // uart_frame_rx
`default_nettype wire

//--- src/altimeter_serial_reader.v
/*
 * Altimeter serial reader: receives altimeter ASCII lines, strips
 * spaces, parses altitude, temperature and depth per configured type,
 * and polls the polled type with an interrogation character.
 * Assumes alt_type is static while in use and rx_line is synchronous.
 */
// Function
// (RULE1) Mark7 type: 2400 baud, 7 data, start, mark and stop bits.
// (RULE2) Sensor sends T temp, space, R altitude, CR LF.
// (RULE3) Optional pressure sensor prefixes D depth and space.
// (RULE4) Bathy type: 9600 baud, 8 data, 1 stop, no parity.
// (RULE5) Dual type: 4800 baud, 8 data, 2 stop, no parity.
// (RULE6) Dual type accepts two altitude fields separated by one space; the code strips spaces and splits the fields at a comma.
// (RULE7) Dual type auxiliary fields are ignored.
// (RULE8) Polled type: 9600 baud, 8 data, 1 stop, no parity.
// (RULE9) Polled reply: five-digit depth cm, comma, altitude cm, CR LF.
// (RULE10) Polled sensor replies only after an uppercase D.
// (RULE11) Device sends D automatically to request each polled string.
// (RULE12) Other types stream unprompted from power-on.
// (RULE13) All spaces are removed before field interpretation.
// (RULE14) Framing and layout follow the configured altimeter type.
// (RULE15) Only complete CR LF lines are interpreted; bad lines dropped.
`default_nettype none
`include "alt_reader_regs.vh"

module altimeter_serial_reader #(
    parameter CLK_FREQ    = `CLK_HZ,
    parameter POLL_CYCLES = CLK_FREQ / 1000 * `POLL_PERIOD_MS
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        sys_rst,
    // Configuration
    input  wire [1:0]  alt_type,
    // Serial link
    input  wire        rx_line,
    output reg         tx_line_q,
    // Parsed results, value in tenths or centimetres
    output reg  [19:0] altitude_q,
    output reg  [19:0] temperature_q,
    output reg         temp_neg_q,
    output reg  [19:0] depth_q,
    output reg         depth_valid_q,
    output reg         line_valid_q,
    output reg         line_drop_q
);

    localparam DIV_W = 16;
    // Bit times in clocks, cut to the counter width on purpose
    localparam integer LEN_2400 = CLK_FREQ / `BAUD_MARK7 - 1;
    localparam integer LEN_9600 = CLK_FREQ / `BAUD_BATHY - 1;
    localparam integer LEN_4800 = CLK_FREQ / `BAUD_DUAL - 1;
    localparam [DIV_W-1:0] DIV_2400 = LEN_2400[DIV_W-1:0];
    localparam [DIV_W-1:0] DIV_9600 = LEN_9600[DIV_W-1:0];
    localparam [DIV_W-1:0] DIV_4800 = LEN_4800[DIV_W-1:0];

    // Field parser states, one-hot
    localparam F_TAG = 5'b00001;
    localparam F_NUM = 5'b00010;
    localparam F_LF  = 5'b00100;
    localparam F_BAD = 5'b01000;
    localparam F_AUX = 5'b10000;

    // ********
    // Framing select per type
    // ********
    reg [DIV_W-1:0] bit_div;
    reg [3:0]       data_bits;
    reg             mark_bit;
    reg [1:0]       stop_bits;
    always @* begin
        bit_div   = DIV_9600;
        data_bits = `BITS_EIGHT;
        mark_bit  = 1'b0;
        stop_bits = `STOP_ONE;
        case (alt_type)
            `ALT_TYPE_MARK7: begin
                bit_div   = DIV_2400; // RULE1
                data_bits = `BITS_SEVEN;
                mark_bit  = 1'b1;
            end
            `ALT_TYPE_DUAL: begin
                bit_div   = DIV_4800; // RULE5
                stop_bits = `STOP_TWO;
            end
            default: bit_div = DIV_9600; // RULE4 RULE8 RULE14
        endcase
    end

    wire [7:0] rx_data;
    wire       rx_valid;
    wire       rx_err;

    uart_frame_rx #(.DIV_W(DIV_W)) u_rx (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .bit_div    (bit_div),
        .data_bits  (data_bits),
        .mark_bit   (mark_bit),
        .stop_bits  (stop_bits),
        .rx_line    (rx_line),
        .rx_data_q  (rx_data),
        .rx_valid_q (rx_valid),
        .rx_err_q   (rx_err)
    );

    function is_digit;
        input [7:0] c;
        is_digit = (c >= `CH_ZERO) && (c <= `CH_NINE);
    endfunction

    function [19:0] acc_digit;
        input [19:0] v;
        input [7:0]  c;
        acc_digit = v * 20'd10 + {16'h0000, c[3:0]};
    endfunction

    // ********
    // Line parser
    // ********
    reg [4:0]  fst_q;
    reg [19:0] num_q;
    reg        neg_q;
    reg [1:0]  fld_q;     // 0 none, 1 T, 2 R/alt, 3 D/depth
    reg [1:0]  idx_q;     // Field index in comma or dual layouts
    reg [19:0] alt_q;
    reg [19:0] tmp_q;
    reg        tneg_q;
    reg [19:0] dep_q;
    reg        has_alt_q;
    reg        has_dep_q;
    reg        has_tmp_q;
    reg [7:0]  len_q;

    wire is_lettered = (alt_type == `ALT_TYPE_MARK7);
    wire [1:0] num_fld = (alt_type == `ALT_TYPE_POLLED) ?
                         ((idx_q == 2'd0) ? 2'd3 : 2'd2) : 2'd2;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            fst_q <= F_TAG; num_q <= 20'h0_0000; neg_q <= 1'b0;
            fld_q <= 2'd0; idx_q <= 2'd0; alt_q <= 20'h0_0000;
            tmp_q <= 20'h0_0000; tneg_q <= 1'b0; dep_q <= 20'h0_0000;
            has_alt_q <= 1'b0; has_dep_q <= 1'b0; has_tmp_q <= 1'b0;
            len_q <= 8'h00;
            altitude_q <= 20'h0_0000; temperature_q <= 20'h0_0000;
            temp_neg_q <= 1'b0; depth_q <= 20'h0_0000;
            depth_valid_q <= 1'b0; line_valid_q <= 1'b0; line_drop_q <= 1'b0;
        end else begin
            line_valid_q <= 1'b0;
            line_drop_q  <= 1'b0;
            if (rx_err) begin
                fst_q <= F_BAD; // RULE15
            end else if (rx_valid && rx_data != `CH_SPACE) begin // RULE13
                len_q <= len_q + 8'h01;
                if (len_q == `MAX_LINE_CHARS && rx_data != `CH_LF)
                    fst_q <= F_BAD;
                else case (fst_q)
                    F_TAG, F_NUM: begin
                        if (rx_data == `CH_CR) begin
                            fst_q <= F_LF;
                            if (fld_q == 2'd1) begin tmp_q <= num_q; tneg_q <= neg_q; end
                            if (fld_q == 2'd2 && !has_alt_q) begin
                                alt_q <= num_q; has_alt_q <= 1'b1;
                            end
                            if (fld_q == 2'd3) begin dep_q <= num_q; has_dep_q <= 1'b1; end
                        end else if (is_lettered && (rx_data == `CH_T ||
                                     rx_data == `CH_R || rx_data == `CH_D)) begin
                            // Close a previous T or D field, open the tagged one
                            if (fld_q == 2'd1) begin
                                tmp_q <= num_q; tneg_q <= neg_q; has_tmp_q <= 1'b1;
                            end
                            if (fld_q == 2'd3) begin dep_q <= num_q; has_dep_q <= 1'b1; end
                            fld_q <= (rx_data == `CH_T) ? 2'd1 : // RULE2
                                     (rx_data == `CH_R) ? 2'd2 : 2'd3; // RULE3
                            num_q <= 20'h0_0000; neg_q <= 1'b0; fst_q <= F_NUM;
                        end else if (rx_data == `CH_COMMA && !is_lettered) begin
                            if (num_fld == 2'd3) begin dep_q <= num_q; has_dep_q <= 1'b1; end
                            else if (!has_alt_q) begin alt_q <= num_q; has_alt_q <= 1'b1; end
                            idx_q <= idx_q + 2'd1; // RULE9
                            num_q <= 20'h0_0000;
                            fld_q <= 2'd2;
                            // Dual type: fields after the altitudes are external
                            if (alt_type == `ALT_TYPE_DUAL && has_alt_q)
                                fst_q <= F_AUX; // RULE7
                        end else if (is_digit(rx_data)) begin
                            num_q <= acc_digit(num_q, rx_data);
                            if (!is_lettered) fld_q <= num_fld;
                            fst_q <= F_NUM;
                        end else if (rx_data == `CH_MINUS && fld_q == 2'd1) begin
                            neg_q <= 1'b1;
                        end else if (rx_data != `CH_DOT) begin
                            fst_q <= F_BAD;
                        end
                    end
                    F_AUX: if (rx_data == `CH_CR) fst_q <= F_LF;
                    F_LF: begin
                        if (rx_data == `CH_LF && has_alt_q) begin
                            // Only the first of the dual altitudes is kept
                            altitude_q <= alt_q; // RULE6
                            temperature_q <= tmp_q;
                            temp_neg_q <= tneg_q;
                            depth_q <= dep_q;
                            depth_valid_q <= has_dep_q;
                            line_valid_q <= 1'b1; // RULE15
                        end else begin
                            line_drop_q <= 1'b1;
                        end
                        fst_q <= F_TAG; num_q <= 20'h0_0000; neg_q <= 1'b0;
                        fld_q <= 2'd0; idx_q <= 2'd0; len_q <= 8'h00;
                        has_alt_q <= 1'b0; has_dep_q <= 1'b0; has_tmp_q <= 1'b0;
                    end
                    F_BAD: if (rx_data == `CH_LF) begin
                        line_drop_q <= 1'b1;
                        fst_q <= F_TAG; num_q <= 20'h0_0000; neg_q <= 1'b0;
                        fld_q <= 2'd0; idx_q <= 2'd0; len_q <= 8'h00;
                        has_alt_q <= 1'b0; has_dep_q <= 1'b0; has_tmp_q <= 1'b0;
                    end
                    default: fst_q <= F_BAD;
                endcase
            end
        end
    end

    // ********
    // Interrogation transmitter, polled type only
    // ********
    localparam [9:0] TX_FRAME = {1'b1, `CH_D, 1'b0};
    reg [31:0]      poll_cnt_q;
    reg [DIV_W-1:0] tx_cnt_q;
    reg [3:0]       tx_bit_q;
    reg [9:0]       tx_sh_q;
    reg             tx_busy_q;

    // Other types stream unprompted, so the line stays idle for them
    always @(posedge core_clk) begin
        if (sys_rst) begin
            poll_cnt_q <= 32'h0000_0000; tx_cnt_q <= {DIV_W{1'b0}};
            tx_bit_q <= 4'h0; tx_sh_q <= 10'h3FF; tx_busy_q <= 1'b0;
            tx_line_q <= 1'b1;
        end else if (tx_busy_q) begin
            if (tx_cnt_q != {DIV_W{1'b0}}) begin
                tx_cnt_q <= tx_cnt_q - 1'b1;
            end else begin
                tx_cnt_q  <= DIV_9600;
                tx_line_q <= tx_sh_q[0];
                tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
                tx_bit_q  <= tx_bit_q + 4'h1;
                if (tx_bit_q == 4'd10) tx_busy_q <= 1'b0;
            end
        end else if (alt_type == `ALT_TYPE_POLLED) begin // RULE12
            tx_line_q <= 1'b1;
            // One request per line, or on timeout if a reply is lost
            if (line_valid_q || line_drop_q ||
                poll_cnt_q >= POLL_CYCLES - 1) begin
                poll_cnt_q <= 32'h0000_0000;
                tx_sh_q    <= TX_FRAME; // RULE10 RULE11
                tx_bit_q   <= 4'h0;
                tx_cnt_q   <= {DIV_W{1'b0}};
                tx_busy_q  <= 1'b1;
            end else begin
                poll_cnt_q <= poll_cnt_q + 32'h0000_0001;
            end
        end else begin
            poll_cnt_q <= 32'h0000_0000;
            tx_line_q  <= 1'b1;
        end
    end

endmodule // altimeter_serial_reader
`default_nettype wire

//--- sim/alt_reader_assertions.sv
/*
 * Port-level checks for the altimeter serial reader.
 * Assumes it is bound to the reader top, one clock, sync reset.
 */
`default_nettype none

module alt_reader_checker #(
    parameter CLK_FREQ = 40000000
) (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // Configuration and link
    input wire logic [1:0]  alt_type,
    input wire logic        rx_line,
    input wire logic        tx_line_q,
    // Results
    input wire logic [19:0] altitude_q,
    input wire logic [19:0] temperature_q,
    input wire logic        temp_neg_q,
    input wire logic [19:0] depth_q,
    input wire logic        depth_valid_q,
    input wire logic        line_valid_q,
    input wire logic        line_drop_q
);
    timeunit 1ns;
    timeprecision 1ps;

    // One poll bit in clocks at 9600 baud
    localparam int BIT_CYC = CLK_FREQ / 9600;

    // ********
    // Helper counters
    // ********
    logic [15:0] lo_cnt_q;
    logic [15:0] gap_q;
    logic        armed_q;

    // Length of each low run on the poll output
    always @(posedge core_clk) begin
        if (sys_rst || tx_line_q) lo_cnt_q <= 16'h0000;
        else lo_cnt_q <= lo_cnt_q + 16'h0001;
    end

    // Wait from a finished polled line to the next start bit
    always @(posedge core_clk) begin
        if (sys_rst || !tx_line_q) begin
            armed_q <= 1'b0;
            gap_q   <= 16'h0000;
        end else if ((line_valid_q || line_drop_q) && alt_type == 2'h3) begin
            armed_q <= 1'b1;
            gap_q   <= 16'h0000;
        end else if (armed_q) begin
            gap_q <= gap_q + 16'h0001;
        end
    end

    // ********
    // Properties
    // ********
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_quiet_tx;
        alt_type != 2'h3 |-> tx_line_q;
    endproperty
    a_quiet_tx: assert property (p_quiet_tx)
        else $error("tx line active outside polled type");

    property p_one_verdict;
        !(line_valid_q && line_drop_q);
    endproperty
    a_one_verdict: assert property (p_one_verdict)
        else $error("line both accepted and dropped");

    property p_valid_pulse;
        line_valid_q |=> !line_valid_q [*2];
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("line valid longer than one cycle");

    property p_results_hold;
        $changed({altitude_q, depth_q}) |-> ##[0:1] line_valid_q;
    endproperty
    a_results_hold: assert property (p_results_hold)
        else $error("results changed without accepted line");

    property p_polled_depth;
        line_valid_q && alt_type == 2'h3 |-> depth_valid_q;
    endproperty
    a_polled_depth: assert property (p_polled_depth)
        else $error("polled line without depth flag");

    // A poll byte holds low runs of one or three bit times only
    property p_poll_bits;
        $rose(tx_line_q) |-> (lo_cnt_q inside {[BIT_CYC-1:BIT_CYC+1],
                                               [3*BIT_CYC-1:3*BIT_CYC+1]});
    endproperty
    a_poll_bits: assert property (p_poll_bits)
        else $error("poll frame bit timing wrong");

    property p_end_idle;
        line_valid_q |-> $past(rx_line, 1) && $past(rx_line, 2);
    endproperty
    a_end_idle: assert property (p_end_idle)
        else $error("line accepted while rx not at stop level");

    property p_prompt_poll;
        armed_q |-> gap_q < 16'd8400;
    endproperty
    a_prompt_poll: assert property (p_prompt_poll)
        else $error("next poll not sent after polled line");
endmodule // alt_reader_checker

`default_nettype wire

//--- sim/altimeter_model.sv
/*
 * Behavioural altimeter on the far side of the serial link.
 * Assumes the bench calls send_line at a falling clock edge.
 */
`default_nettype none

module altimeter_model #(parameter CLK_FREQ = 40000000) (
    // Clock and configuration
    input wire logic       core_clk,
    input wire logic [1:0] alt_type,
    // Link as seen by the sensor
    input wire logic       tx_line_q,
    output logic           rx_line
);
    timeunit 1ns;
    timeprecision 1ps;

    int         poll_count;
    int         served;
    logic [7:0] poll_char;

    // RS232 idles at the mark level
    initial begin
        rx_line    = 1'b1;
        poll_count = 0;
        served     = 0;
        poll_char  = 8'h00;
    end

    // ********
    // Transmit side
    // ********
    function automatic int bit_cyc();
        if (alt_type == 2'h0) return CLK_FREQ / 2400;
        if (alt_type == 2'h2) return CLK_FREQ / 4800;
        return CLK_FREQ / 9600;
    endfunction

    task automatic send_char(input logic [7:0] c);
        logic [11:0] fr;
        int          n;
        if (alt_type == 2'h0) fr = {3'b111, c[6:0], 1'b0};
        else fr = {3'b111, c, 1'b0};
        n = (alt_type == 2'h2) ? 11 : 10;
        for (int k = 0; k < n; k++) begin
            rx_line = fr[k];
            repeat (bit_cyc()) @(negedge core_clk);
        end
    endtask

    // One line; the polled sensor waits for its own request first
    task automatic send_line(input string s);
        if (alt_type == 2'h3) begin
            wait (poll_count > served);
            served++;
            @(negedge core_clk);
        end
        for (int i = 0; i < s.len(); i++) send_char(s[i]);
    endtask

    // ********
    // Request decoder, 9600 8N1, sampled mid-bit
    // ********
    always begin : poll_rx
        logic [7:0] c;
        @(negedge tx_line_q);
        repeat (CLK_FREQ / 9600 / 2) @(posedge core_clk);
        for (int k = 0; k < 8; k++) begin
            repeat (CLK_FREQ / 9600) @(posedge core_clk);
            c[k] = tx_line_q;
        end
        repeat (CLK_FREQ / 9600) @(posedge core_clk);
        poll_char  = c;
        poll_count++;
    end
endmodule // altimeter_model

`default_nettype wire

//--- sim/altimeter_serial_reader_tb.sv
/*
 * Self-checking bench for the altimeter serial reader.
 * Assumes the partner model and checker files compile first.
 */
`default_nettype none

module altimeter_serial_reader_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [19:0] alt;
        logic [19:0] temp;
        logic [19:0] dep;
        logic        ct;
        logic        cd;
        logic        good;
    } note_t;

    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    logic [1:0]  alt_type = 2'h1;
    wire         rx_line;
    wire         tx_line_q;
    wire  [19:0] altitude_q;
    wire  [19:0] temperature_q;
    wire         temp_neg_q;
    wire  [19:0] depth_q;
    wire         depth_valid_q;
    wire         line_valid_q;
    wire         line_drop_q;
    int          failures   = 0;
    int          n_compared = 0;
    int          cyc        = 0;
    int          seed;
    int          dg[6];
    note_t       notes[$];
    note_t       n;

    always #12.5 core_clk = ~core_clk;

    // Scaled bit times keep the run short; timeout outlasts a reply
    altimeter_serial_reader #(.CLK_FREQ(480000), .POLL_CYCLES(8000)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .alt_type(alt_type),
        .rx_line(rx_line), .tx_line_q(tx_line_q), .altitude_q(altitude_q),
        .temperature_q(temperature_q), .temp_neg_q(temp_neg_q),
        .depth_q(depth_q), .depth_valid_q(depth_valid_q),
        .line_valid_q(line_valid_q), .line_drop_q(line_drop_q)
    );

    altimeter_model #(.CLK_FREQ(480000)) partner (
        .core_clk(core_clk), .alt_type(alt_type),
        .tx_line_q(tx_line_q), .rx_line(rx_line)
    );

    // ********************************************************
    // Compare and report
    // ********************************************************
    task automatic cmp20(input string what, input logic [19:0] e, input logic [19:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", what, e, g);
        end
    endtask

    task automatic cmp1(input string what, input logic e, input logic g);
        cmp20(what, {19'h0_0000, e}, {19'h0_0000, g});
    endtask

    task automatic report_and_stop();
        if (failures == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ********************************************************
    // Stimulus helpers
    // ********************************************************
    task automatic do_reset(input logic [1:0] t);
        @(negedge core_clk);
        sys_rst  = 1'b1;
        alt_type = t;
        repeat (16) @(negedge core_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 6; i++) dg[i] = $unsigned($random(seed)) % 10;
    endtask

    task automatic expect_line(input int a, input int t, input int d, input logic ct,
                               input logic cd, input logic good);
        notes.push_back('{20'(a), 20'(t), 20'(d), ct, cd, good});
    endtask

    // Bounded wait for the n-th request byte, then check it
    task automatic wait_poll(input int k);
        for (int i = 0; i < 60000 && partner.poll_count < k; i++) @(negedge core_clk);
        cmp1("poll seen", 1'b1, partner.poll_count >= k);
        cmp20("poll char", 20'h0_0044, {12'h000, partner.poll_char});
    endtask

    // Oldest note against each line verdict
    always @(negedge core_clk) begin
        if (line_valid_q === 1'b1 || line_drop_q === 1'b1) begin
            if (notes.size() == 0) begin
                cmp1("unexpected line", 1'b0, 1'b1);
            end else begin
                n = notes.pop_front();
                cmp1("line_valid_q", n.good, line_valid_q);
                if (n.good) cmp20("altitude_q", n.alt, altitude_q);
                if (n.good && n.ct) cmp20("temperature_q", n.temp, temperature_q);
                if (n.good && n.ct) cmp1("temp_neg_q", 1'b0, temp_neg_q);
                if (n.good) cmp1("depth_valid_q", n.cd, depth_valid_q);
                if (n.good && n.cd) cmp20("depth_q", n.dep, depth_q);
            end
        end
    end

    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 150000) begin
            failures++;
            report_and_stop();
        end
    end

    // ********************************************************
    // Scenarios
    // ********************************************************
    initial begin
        seed = 32'h1eba;
        // Streaming type, space inside the altitude, then junk
        do_reset(2'h1);
        expect_line(dg[0] * 10 + dg[1], 0, 0, 1'b0, 1'b0, 1'b1);
        partner.send_line($sformatf("%0d %0d,%0d\015\012", dg[0], dg[1], dg[2]));
        expect_line(0, 0, 0, 1'b0, 1'b0, 1'b0);
        partner.send_line("X\015\012");
        // Two stop bits, auxiliary field must not matter
        do_reset(2'h2);
        expect_line(dg[0], 0, 0, 1'b0, 1'b0, 1'b1);
        partner.send_line($sformatf("%0d,%0d,Z\015\012", dg[0], dg[1]));
        // Polled type: request, reply, next request
        do_reset(2'h3);
        wait_poll(1);
        expect_line(dg[1] * 10 + dg[2], 0, dg[0], 1'b0, 1'b1, 1'b1);
        partner.send_line($sformatf("0000%0d,%0d%0d\015\012", dg[0], dg[1], dg[2]));
        wait_poll(2);
        // Seven-bit framing with depth prefix
        do_reset(2'h0);
        expect_line(dg[4] * 10 + dg[5], dg[2] * 10 + dg[3], dg[0] * 10 + dg[1],
                    1'b1, 1'b1, 1'b1);
        partner.send_line($sformatf("D%0d.%0d T%0d.%0d R%0d.%0d\015\012",
                          dg[0], dg[1], dg[2], dg[3], dg[4], dg[5]));
        repeat (20) @(negedge core_clk);
        cmp20("pending notes", 20'h0_0000, 20'(notes.size()));
        report_and_stop();
    end
endmodule // altimeter_serial_reader_tb

bind altimeter_serial_reader alt_reader_checker #(.CLK_FREQ(CLK_FREQ)) chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .alt_type(alt_type),
    .rx_line(rx_line), .tx_line_q(tx_line_q), .altitude_q(altitude_q),
    .temperature_q(temperature_q), .temp_neg_q(temp_neg_q),
    .depth_q(depth_q), .depth_valid_q(depth_valid_q),
    .line_valid_q(line_valid_q), .line_drop_q(line_drop_q)
);

`default_nettype wire
